//--- bench/tcf_tb.sv
// Self-checking bench for the timer channel A event status block.
`timescale 1ns/1ps
`include "tcf_params.svh"
module tb;
   import tcf_pkg::*;

   // ************************************************************
   // Stimulus and observation signals
   // ************************************************************
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [19:0] paddr   = 20'h00000;
   logic [31:0] pwdata  = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [47:0] cnt     = 48'h000000000000;
   logic [47:0] cmp     = 48'h000100010001;
   logic [2:0]  cap     = 3'h0;
   logic [2:0]  dack    = 3'h0;
   logic [2:0]  req;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          n_fail       = 0;
   int          total_checks = 0;

   // The clock toggles every half period of 2 ns.
   always #2 sys_clk = ~sys_clk;

   tcf_top u_dut (
      .sys_clk             (sys_clk),
      .rst_n               (rst_n),
      .psel                (psel),
      .penable             (penable),
      .pwrite              (pwrite),
      .paddr               (paddr),
      .pwdata              (pwdata),
      .prdata              (prdata),
      .pready              (pready),
      .pslverr             (pslverr),
      .channel_counter     (cnt),
      .general_compare_reg (cmp),
      .capture_pin         (cap),
      .dma_unit_ack        (dack),
      .match_event_request (req),
      .irq                 (irq)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      err = pslverr;
      rd  = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Reset values of the status and interrupt mask registers and of the outputs.
   task automatic t_reset();
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd, 32'h00000088);
      apb(1'b0, `TCF_ADDR_IRQ_MASK, 32'h0);
      chk(rd, 32'h0);
      chk({28'h0, req, irq}, 32'h0);
   endtask

   // One cycle of equality on channel 0, then the clearing sequence.
   task automatic t_compare();
      apb(1'b1, `TCF_ADDR_STATUS, 32'h10);
      @(posedge sys_clk);
      cnt[15:0] <= 16'h1234;
      cmp[15:0] <= 16'h1234;
      @(posedge sys_clk);
      cnt[15:0] <= 16'h0000;
      repeat (2) @(posedge sys_clk);
      chk({29'h0, req}, 32'h1);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h99);
      apb(1'b1, `TCF_ADDR_STATUS, 32'h11);
      apb(1'b1, `TCF_ADDR_STATUS, 32'h10);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h99);
      apb(1'b1, `TCF_ADDR_STATUS, 32'h10);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h98);
      chk({29'h0, req}, 32'h0);
   endtask

   // Captures on channels 1 and 2, then a DMA start clears channel 2.
   task automatic t_capture();
      apb(1'b1, `TCF_ADDR_CTRL, 32'h6);
      apb(1'b1, `TCF_ADDR_STATUS, 32'h0);
      cap <= 3'h6;
      repeat (5) @(posedge sys_clk);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h8e);
      chk({29'h0, req}, 32'h0);
      dack <= 3'h4;
      @(posedge sys_clk);
      dack <= 3'h0;
      repeat (2) @(posedge sys_clk);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h8a);
      apb(1'b1, `TCF_ADDR_STATUS, 32'h0);
      cap <= 3'h0;
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk(rd & 32'hff, 32'h88);
   endtask

   // Sticky events are masked, unmasked and cleared by writing ones.
   task automatic t_irq();
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, `TCF_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h7);
      apb(1'b1, `TCF_ADDR_IRQ_MASK, 32'h2);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `TCF_ADDR_IRQ_STAT, 32'h7);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, `TCF_ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
   endtask

   // An unmapped place is refused and reads as zero.
   task automatic t_unmapped();
      apb(1'b1, 20'hfff74, 32'hffffffff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 20'hfff74, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `TCF_ADDR_STATUS, 32'h0);
      chk({31'h0, err}, 32'h0);
      chk(rd & 32'hff, 32'h88);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   // Holds reset for 20 cycles, then runs every scenario.
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_compare();
      t_capture();
      t_irq();
      t_unmapped();
      finish_test();
   end

   // Cuts a hang short well beyond the roughly 120 cycles needed.
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      finish_test();
   end
endmodule

//--- core/tcf_chan_flag.sv
// Flag, enable and request logic of one timer channel.
`timescale 1ns/1ps
module tcf_chan_flag
   import tcf_pkg::*;
(
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Channel events.
   input  wire logic       match_evt,
   input  wire logic       capture_evt,
   input  wire tcf_mode_t  mode,
   input  wire logic       dma_ack,
   // Software access to the flag.
   input  wire logic       flag_read,
   input  wire logic       flag_write,
   input  wire logic       flag_wdata,
   input  wire logic       en_write,
   input  wire logic       en_wdata,
   // Outputs.
   output logic            flag,
   output logic            irq_en,
   output logic            request,
   output logic            event_pulse
);

   typedef struct packed {
      logic     flag;
      logic     en;
      tcf_arm_t arm;
      logic     evt;
   } tcf_chan_state_t;

   tcf_chan_state_t st;
   tcf_chan_state_t next_st;
   logic            set_evt;

   // Event selection by mode; set wins over any clear in the same cycle.
   always_comb begin
      next_st = st;
      set_evt = (mode == TCF_MODE_COMPARE) ? match_evt : capture_evt;
      next_st.evt = set_evt;
      if (flag_read && st.flag) begin
         next_st.arm = TCF_ARMED;
      end
      if (flag_write) begin
         if (!flag_wdata && st.arm == TCF_ARMED) begin
            next_st.flag = 1'b0;
         end
         next_st.arm = TCF_IDLE;
      end
      if (dma_ack) begin
         next_st.flag = 1'b0;
         next_st.arm  = TCF_IDLE;
      end
      if (set_evt) begin
         next_st.flag = 1'b1;
      end
      if (en_write) begin
         next_st.en = en_wdata;
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '{flag: 1'b0, en: 1'b0, arm: TCF_IDLE, evt: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign flag        = st.flag;
   assign irq_en      = st.en;
   assign request     = st.flag & st.en;
   assign event_pulse = st.evt;

   a_set_on_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
      set_evt |=> flag) else $error("flag not set after event");
   a_req_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      request == (flag && irq_en)) else $error("request not gated");
   a_dma_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dma_ack && !set_evt |=> !flag) else $error("dma did not clear");
   a_write_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      flag_write && flag_wdata && !dma_ack && flag |=> flag)
      else $error("write one changed flag");

endmodule

//--- core/tcf_params.svh
// Constants for the timer channel A event status block.
`ifndef TCF_PARAMS_SVH
`define TCF_PARAMS_SVH

// Register byte address of the event status register, and of own extras.
`define TCF_ADDR_STATUS   20'hfff64
`define TCF_ADDR_CTRL     20'hfff68
`define TCF_ADDR_IRQ_STAT 20'hfff6c
`define TCF_ADDR_IRQ_MASK 20'hfff70

// Field positions in the event status register.
`define TCF_FLAG_LSB 0
`define TCF_EN_LSB   4
`define TCF_RSV_HI   7
`define TCF_RSV_LO   3

// Reset value of the event status register.
`define TCF_STATUS_RESET 8'h88

// Number of channels.
`define TCF_NCH 3

`endif

//--- core/tcf_pkg.sv
// Types shared by the timer channel A event status block.
package tcf_pkg;

   // Per channel mode of the general compare register.
   typedef enum logic {
      TCF_MODE_COMPARE,
      TCF_MODE_CAPTURE
   } tcf_mode_t;

   // Software clear arming state of one flag.
   typedef enum logic [1:0] {
      TCF_IDLE,
      TCF_ARMED
   } tcf_arm_t;

endpackage

//--- core/tcf_sync2.sv
// Two-flop synchroniser for one pin level.
`timescale 1ns/1ps
module tcf_sync2
   import tcf_pkg::*;
(
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Level in and out.
   input  wire logic din,
   output logic      dout
);

   typedef struct packed {
      logic s1;
      logic s2;
   } tcf_sync_state_t;

   tcf_sync_state_t st;
   tcf_sync_state_t next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.s2;

endmodule

//--- core/tcf_top.sv
// Timer channel A compare/capture event flags with APB register access.
//
// Function
// - capture transfer sets the channel flag
// - clear by reading one then writing zero
// - DMA start by event clears flag
// - enable bit gates the interrupt request
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tcf_params.svh"
module tcf_top
   import tcf_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer channel inputs.
   input  wire logic [47:0] channel_counter,
   input  wire logic [47:0] general_compare_reg,
   input  wire logic [2:0]  capture_pin,
   input  wire logic [2:0]  dma_unit_ack,
   // Outputs.
   output logic      [2:0]  match_event_request,
   output logic             irq
);

   localparam int NCH = `TCF_NCH;

   typedef struct packed {
      logic [31:0] rdata;
      logic [2:0]  mode;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        done;
   } tcf_top_state_t;

   tcf_top_state_t st;
   tcf_top_state_t next_st;

   logic [2:0] cap_sync;
   logic [2:0] cap_prev;
   logic [2:0] flags;
   logic [2:0] ens;
   logic [2:0] evts;
   logic [2:0] reqs;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       rd_load;
   logic       hit_status;
   logic       hit_ctrl;
   logic       hit_stat;
   logic       hit_mask;

   // ****************************************
   // Bus decode.
   // ****************************************

   // Address decode; unmapped addresses answer with an error.
   always_comb begin
      hit_status = 1'b0;
      hit_ctrl   = 1'b0;
      hit_stat   = 1'b0;
      hit_mask   = 1'b0;
      if (paddr == `TCF_ADDR_STATUS) begin
         hit_status = 1'b1;
      end else if (paddr == `TCF_ADDR_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (paddr == `TCF_ADDR_IRQ_STAT) begin
         hit_stat = 1'b1;
      end else if (paddr == `TCF_ADDR_IRQ_MASK) begin
         hit_mask = 1'b1;
      end
   end

   // One wait state loads the read data register, so the data stand at the ready edge.
   assign acc     = psel & penable;
   assign pready  = acc & st.done;
   assign wr      = pready & pwrite;
   assign rd      = pready & ~pwrite;
   assign rd_load = acc & ~pwrite & ~st.done;
   assign pslverr = pready & ~(hit_status | hit_ctrl | hit_stat | hit_mask);

   // ****************************************
   // Channels.
   // ****************************************

   // Capture pins come from outside and are synchronised, then edge detected.
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         tcf_sync2 u_sync (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .din     (capture_pin[g]),
            .dout    (cap_sync[g])
         );
         tcf_chan_flag u_chan (
            .sys_clk     (sys_clk),
            .rst_n       (rst_n),
            .match_evt   (channel_counter[g*16 +: 16] ==
                          general_compare_reg[g*16 +: 16]),
            .capture_evt (cap_sync[g] & ~cap_prev[g]),
            .mode        (tcf_mode_t'(st.mode[g])),
            .dma_ack     (dma_unit_ack[g]),
            .flag_read   (rd & hit_status),
            .flag_write  (wr & hit_status),
            .flag_wdata  (pwdata[`TCF_FLAG_LSB + g]),
            .en_write    (wr & hit_status),
            .en_wdata    (pwdata[`TCF_EN_LSB + g]),
            .flag        (flags[g]),
            .irq_en      (ens[g]),
            .request     (reqs[g]),
            .event_pulse (evts[g])
         );
      end
   endgenerate

   // Previous synchronised capture level for rising edge detection.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cap_prev <= 3'h0;
      end else begin
         cap_prev <= cap_sync;
      end
   end

   // ****************************************
   // Registers.
   // ****************************************

   // Read data register, mode control and sticky interrupt status.
   always_comb begin
      next_st      = st;
      next_st.done = acc & ~st.done;
      if (rd_load) begin
         if (hit_status) begin
            next_st.rdata = {24'h0, 1'b1, ens, 1'b1, flags};
         end else if (hit_ctrl) begin
            next_st.rdata = {29'h0, st.mode};
         end else if (hit_stat) begin
            next_st.rdata = {29'h0, st.irq_stat};
         end else if (hit_mask) begin
            next_st.rdata = {29'h0, st.irq_mask};
         end else begin
            next_st.rdata = 32'h0;
         end
      end
      if (wr && hit_ctrl) begin
         next_st.mode = pwdata[2:0];
      end
      if (wr && hit_mask) begin
         next_st.irq_mask = pwdata[2:0];
      end
      if (wr && hit_stat) begin
         next_st.irq_stat = st.irq_stat & ~pwdata[2:0];
      end
      next_st.irq_stat = next_st.irq_stat | evts;
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata              = st.rdata;
   assign match_event_request = reqs;
   assign irq                 = |(st.irq_stat & st.irq_mask);

   a_status_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd && hit_status |=> prdata[7] && prdata[3])
      else $error("reserved bits not one");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(evts[0]) && st.irq_mask[0] |=> irq)
      else $error("irq not raised");
   a_chan_indep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dma_unit_ack == 3'h1 && !evts[1] && !(wr && hit_status) && flags[1] |=> flags[1])
      else $error("channel crosstalk");
   a_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      g_ch[0].u_chan.st.arm == TCF_ARMED && wr && hit_status && !pwdata[0]
      && !dma_unit_ack[0] && !(g_ch[0].u_chan.set_evt) |=> !flags[0])
      else $error("read then zero did not clear");

endmodule
